// file: src/csi_hs_timing_override_regs.sv
// Our own choice: the APB slave port.
`timescale 1ns/10ps
// Notes on behaviour
// - hs-zero uses automatic value unless override bit set, then field.
// - hs-trail uses automatic value unless override bit set, then field.
// - hs-exit uses automatic value unless override bit set, then field.
// - plx uses automatic value unless override bit set, then field.
// - override clear: value field reads current automatic value, ignores.
// - override set: value field writable, reads back stored override.
module csi_hs_timing_override_regs
(
    input  wire logic                             pclk,
    input  wire logic                             presetn,
    input  wire logic                             clk_en,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [hs_timing_pkg::ADDR_W-1:0] paddr,
    input  wire logic [31:0]                      pwdata,
    input  wire logic [3:0]                       pstrb,
    output logic      [31:0]                      prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    input  wire logic [hs_timing_pkg::VAL_W-1:0]  hs_zero_auto,
    input  wire logic [hs_timing_pkg::VAL_W-1:0]  hs_trail_auto,
    input  wire logic [hs_timing_pkg::VAL_W-1:0]  hs_exit_auto,
    input  wire logic [hs_timing_pkg::VAL_W-1:0]  plx_auto,
    output logic      [hs_timing_pkg::VAL_W-1:0]  hs_zero_value,
    output logic      [hs_timing_pkg::VAL_W-1:0]  hs_trail_value,
    output logic      [hs_timing_pkg::VAL_W-1:0]  hs_exit_value,
    output logic      [hs_timing_pkg::VAL_W-1:0]  plx_value,
    output logic                                  hs_zero_override_select,
    output logic                                  hs_trail_override_select,
    output logic                                  hs_exit_override_select,
    output logic                                  plx_override_select
);
    import hs_timing_pkg::*;

    logic [VAL_W-1:0] auto_val   [NUM_PARAMS];
    logic [VAL_W-1:0] eff_val    [NUM_PARAMS];
    logic [VAL_W-1:0] ovr_val_ff [NUM_PARAMS];
    logic             ovr_sel_ff [NUM_PARAMS];
    logic [7:0]       reg_byte   [NUM_PARAMS];
    logic [NUM_PARAMS-1:0] hit;
    logic [7:0]       idx_tab    [NUM_PARAMS];
    logic [7:0]       rd_lane    [NUM_PARAMS];
    logic [7:0]       rd_byte;
    logic [31:0]      nxt_rdata;
    logic [31:0]      rdata_ff;

    wire        wr_fire  = clk_en && psel && penable && pwrite;
    wire        rd_fire  = clk_en && psel && penable && !pwrite;
    wire        rd_cap   = clk_en && psel && !penable && !pwrite;
    wire [7:0]  reg_idx  = paddr[ADDR_W-1:2];
    wire        aligned  = (paddr[1:0] == 2'b00);
    wire        mapped   = aligned && (hit != '0);

    assign auto_val[0] = hs_zero_auto;
    assign auto_val[1] = hs_trail_auto;
    assign auto_val[2] = hs_exit_auto;
    assign auto_val[3] = plx_auto;
    assign idx_tab[0]  = IDX_HS_ZERO;
    assign idx_tab[1]  = IDX_HS_TRAIL;
    assign idx_tab[2]  = IDX_HS_EXIT;
    assign idx_tab[3]  = IDX_PLX;

    // zero-wait slave; auto values come from same-clock timing logic
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;

    genvar g;
    generate
        for (g = 0; g < NUM_PARAMS; g++) begin : g_param
            assign hit[g] = aligned && (reg_idx == idx_tab[g]);
            wire wr_g = wr_fire && hit[g] && pstrb[0];
            // override selects between auto and stored value
            assign eff_val[g] = ovr_sel_ff[g] ? ovr_val_ff[g]
                                              : auto_val[g];
            // field reads the live timing in either mode
            assign reg_byte[g] = {ovr_sel_ff[g], eff_val[g]};
            assign rd_lane[g]  = hit[g] ? reg_byte[g] : 8'h00;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ovr_sel_ff[g] <= OV_RESET;
                    ovr_val_ff[g] <= VAL_RESET;
                end else if (wr_g) begin
                    ovr_sel_ff[g] <= pwdata[OV_BIT];
                    // value kept even when bit clear; auto unaffected
                    ovr_val_ff[g] <= pwdata[VAL_W-1:0];
                end
            end
        end
    endgenerate

    // or of the lanes is safe: at most one index matches
    assign rd_byte   = rd_lane[0] | rd_lane[1] | rd_lane[2] | rd_lane[3];
    assign nxt_rdata = rd_cap ? {24'h00_0000, rd_byte} : UNMAPPED_DATA;
    assign prdata    = rdata_ff;

    // caught at setup: data leaves a flop, auto value is one cycle old
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= UNMAPPED_DATA;
        end else if (clk_en) begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign hs_zero_value            = eff_val[0];
    assign hs_trail_value           = eff_val[1];
    assign hs_exit_value            = eff_val[2];
    assign plx_value                = eff_val[3];
    assign hs_zero_override_select  = ovr_sel_ff[0];
    assign hs_trail_override_select = ovr_sel_ff[1];
    assign hs_exit_override_select  = ovr_sel_ff[2];
    assign plx_override_select      = ovr_sel_ff[3];

    property p_zero_sel;
        @(posedge pclk) disable iff (!presetn)
        hs_zero_override_select |-> hs_zero_value == ovr_val_ff[0];
    endproperty
    a_zero_sel: assert property (p_zero_sel)
        else $error("hs zero override not applied");

    property p_zero_auto;
        @(posedge pclk) disable iff (!presetn)
        !hs_zero_override_select |-> hs_zero_value == hs_zero_auto;
    endproperty
    a_zero_auto: assert property (p_zero_auto)
        else $error("hs zero auto not used");

    property p_trail;
        @(posedge pclk) disable iff (!presetn)
        hs_trail_value == (hs_trail_override_select ? ovr_val_ff[1]
                                                     : hs_trail_auto);
    endproperty
    a_trail: assert property (p_trail)
        else $error("hs trail select wrong");

    property p_exit;
        @(posedge pclk) disable iff (!presetn)
        hs_exit_value == (hs_exit_override_select ? ovr_val_ff[2]
                                                   : hs_exit_auto);
    endproperty
    a_exit: assert property (p_exit)
        else $error("hs exit select wrong");

    property p_plx;
        @(posedge pclk) disable iff (!presetn)
        plx_value == (plx_override_select ? ovr_val_ff[3] : plx_auto);
    endproperty
    a_plx: assert property (p_plx)
        else $error("plx select wrong");

    property p_rd_auto;
        @(posedge pclk) disable iff (!presetn)
        (rd_fire && hit[0] && !ovr_sel_ff[0] && $past(clk_en))
            |-> prdata == {24'h00_0000, 1'b0, $past(hs_zero_auto)};
    endproperty
    a_rd_auto: assert property (p_rd_auto)
        else $error("read of auto value wrong");

    property p_wr_back;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && hit[1] && pstrb[0] && pwdata[OV_BIT])
            |=> hs_trail_override_select
                && hs_trail_value == $past(pwdata[VAL_W-1:0]);
    endproperty
    a_wr_back: assert property (p_wr_back)
        else $error("override readback wrong");

    property p_keep_auto;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && hit[2] && pstrb[0] && !pwdata[OV_BIT])
            |=> !hs_exit_override_select
                && hs_exit_value == hs_exit_auto;
    endproperty
    a_keep_auto: assert property (p_keep_auto)
        else $error("write with bit clear changed timing");

    property p_zero_wr_back;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && hit[0] && pstrb[0] && pwdata[OV_BIT])
            |=> hs_zero_override_select
                && hs_zero_value == $past(pwdata[VAL_W-1:0]);
    endproperty
    a_zero_wr_back: assert property (p_zero_wr_back)
        else $error("hs zero override not stored");

    property p_exit_wr_back;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && hit[2] && pstrb[0] && pwdata[OV_BIT])
            |=> hs_exit_override_select
                && hs_exit_value == $past(pwdata[VAL_W-1:0]);
    endproperty
    a_exit_wr_back: assert property (p_exit_wr_back)
        else $error("hs exit override not stored");

    property p_plx_wr_back;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && hit[3] && pstrb[0] && pwdata[OV_BIT])
            |=> plx_override_select
                && plx_value == $past(pwdata[VAL_W-1:0]);
    endproperty
    a_plx_wr_back: assert property (p_plx_wr_back)
        else $error("plx override not stored");

    property p_trail_rd_auto;
        @(posedge pclk) disable iff (!presetn)
        (rd_fire && hit[1] && !ovr_sel_ff[1] && $past(clk_en))
            |-> prdata == {24'h00_0000, 1'b0, $past(hs_trail_auto)};
    endproperty
    a_trail_rd_auto: assert property (p_trail_rd_auto)
        else $error("hs trail auto readback wrong");

    property p_exit_rd_auto;
        @(posedge pclk) disable iff (!presetn)
        (rd_fire && hit[2] && !ovr_sel_ff[2] && $past(clk_en))
            |-> prdata == {24'h00_0000, 1'b0, $past(hs_exit_auto)};
    endproperty
    a_exit_rd_auto: assert property (p_exit_rd_auto)
        else $error("hs exit auto readback wrong");

    property p_plx_rd_auto;
        @(posedge pclk) disable iff (!presetn)
        (rd_fire && hit[3] && !ovr_sel_ff[3] && $past(clk_en))
            |-> prdata == {24'h00_0000, 1'b0, $past(plx_auto)};
    endproperty
    a_plx_rd_auto: assert property (p_plx_rd_auto)
        else $error("plx auto readback wrong");

    property p_zero_rd_ovr;
        @(posedge pclk) disable iff (!presetn)
        (rd_fire && hit[0] && ovr_sel_ff[0] && $past(clk_en))
            |-> prdata == {24'h00_0000, 1'b1, ovr_val_ff[0]};
    endproperty
    a_zero_rd_ovr: assert property (p_zero_rd_ovr)
        else $error("hs zero override readback wrong");

    property p_trail_rd_ovr;
        @(posedge pclk) disable iff (!presetn)
        (rd_fire && hit[1] && ovr_sel_ff[1] && $past(clk_en))
            |-> prdata == {24'h00_0000, 1'b1, ovr_val_ff[1]};
    endproperty
    a_trail_rd_ovr: assert property (p_trail_rd_ovr)
        else $error("hs trail override readback wrong");

    property p_exit_rd_ovr;
        @(posedge pclk) disable iff (!presetn)
        (rd_fire && hit[2] && ovr_sel_ff[2] && $past(clk_en))
            |-> prdata == {24'h00_0000, 1'b1, ovr_val_ff[2]};
    endproperty
    a_exit_rd_ovr: assert property (p_exit_rd_ovr)
        else $error("hs exit override readback wrong");

    property p_plx_rd_ovr;
        @(posedge pclk) disable iff (!presetn)
        (rd_fire && hit[3] && ovr_sel_ff[3] && $past(clk_en))
            |-> prdata == {24'h00_0000, 1'b1, ovr_val_ff[3]};
    endproperty
    a_plx_rd_ovr: assert property (p_plx_rd_ovr)
        else $error("plx override readback wrong");

    property p_zero_keep_auto;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && hit[0] && pstrb[0] && !pwdata[OV_BIT])
            |=> !hs_zero_override_select
                && hs_zero_value == hs_zero_auto;
    endproperty
    a_zero_keep_auto: assert property (p_zero_keep_auto)
        else $error("hs zero write with bit clear changed timing");

    property p_trail_keep_auto;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && hit[1] && pstrb[0] && !pwdata[OV_BIT])
            |=> !hs_trail_override_select
                && hs_trail_value == hs_trail_auto;
    endproperty
    a_trail_keep_auto: assert property (p_trail_keep_auto)
        else $error("hs trail write with bit clear changed timing");

    property p_plx_keep_auto;
        @(posedge pclk) disable iff (!presetn)
        (wr_fire && hit[3] && pstrb[0] && !pwdata[OV_BIT])
            |=> !plx_override_select
                && plx_value == plx_auto;
    endproperty
    a_plx_keep_auto: assert property (p_plx_keep_auto)
        else $error("plx write with bit clear changed timing");

    property p_gate_freeze;
        @(posedge pclk) disable iff (!presetn)
        !clk_en |=> $stable({hs_zero_override_select,
                             hs_trail_override_select,
                             hs_exit_override_select,
                             plx_override_select})
                    && $stable({ovr_val_ff[0], ovr_val_ff[1],
                                ovr_val_ff[2], ovr_val_ff[3]})
                    && $stable(prdata);
    endproperty
    a_gate_freeze: assert property (p_gate_freeze)
        else $error("state moved while clock enable low");

    property p_rd_idle;
        @(posedge pclk) disable iff (!presetn)
        (!(psel && penable) && $past(clk_en)) |-> prdata == UNMAPPED_DATA;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data showing outside an access");
endmodule : csi_hs_timing_override_regs

// file: src/hs_timing_pkg.sv
package hs_timing_pkg;
    // printed offsets are not multiples of four: byte address = 4 * index
    localparam logic [7:0]  IDX_HS_ZERO   = 8'h45;
    localparam logic [7:0]  IDX_HS_TRAIL  = 8'h46;
    localparam logic [7:0]  IDX_HS_EXIT   = 8'h47;
    localparam logic [7:0]  IDX_PLX       = 8'h48;
    localparam int          NUM_PARAMS    = 4;
    localparam int          ADDR_W        = 10;
    localparam int          VAL_W         = 7;
    localparam int          OV_BIT        = 7;
    localparam logic [6:0]  VAL_RESET     = 7'h00;
    localparam logic        OV_RESET      = 1'b0;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : hs_timing_pkg

// file: verification/timing_auto_model.sv
`timescale 1ns/10ps
// stands in for the logic that derives timing values automatically
module timing_auto_model
(
    input  wire logic                            pclk,
    input  wire logic                            presetn,
    input  wire logic                            bump,
    output logic      [hs_timing_pkg::VAL_W-1:0] hs_zero_auto,
    output logic      [hs_timing_pkg::VAL_W-1:0] hs_trail_auto,
    output logic      [hs_timing_pkg::VAL_W-1:0] hs_exit_auto,
    output logic      [hs_timing_pkg::VAL_W-1:0] plx_auto
);
    import hs_timing_pkg::*;

    logic [VAL_W-1:0] base_ff;
    wire  [VAL_W-1:0] nxt_base = bump ? base_ff + 7'h05 : base_ff;
    // distinct per parameter so a crossed lane shows up
    assign hs_zero_auto  = base_ff;
    assign hs_trail_auto = base_ff + 7'h01;
    assign hs_exit_auto  = base_ff + 7'h02;
    assign plx_auto      = base_ff + 7'h03;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) base_ff <= 7'h0A;
        else          base_ff <= nxt_base;
    end
endmodule : timing_auto_model

// file: verification/csi_hs_timing_override_regs_tb.sv
`timescale 1ns/10ps
module csi_hs_timing_override_regs_tb;
    import hs_timing_pkg::*;
    logic              pclk, presetn, clk_en, psel, penable, pwrite, bump;
    logic              pready, pslverr, er;
    logic [ADDR_W-1:0] paddr, a;
    logic [31:0]       pwdata, prdata, rd;
    logic [3:0]        pstrb;
    wire  [VAL_W-1:0]  au[4], ef[4];
    wire               sl[4];
    logic [VAL_W-1:0]  v;
    int                fail_count, n_compared, cyc;
    csi_hs_timing_override_regs csi_hs_timing_override_regs_inst (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .hs_zero_auto(au[0]), .hs_trail_auto(au[1]),
        .hs_exit_auto(au[2]), .plx_auto(au[3]),
        .hs_zero_value(ef[0]), .hs_trail_value(ef[1]),
        .hs_exit_value(ef[2]), .plx_value(ef[3]),
        .hs_zero_override_select(sl[0]), .hs_trail_override_select(sl[1]),
        .hs_exit_override_select(sl[2]), .plx_override_select(sl[3]));
    timing_auto_model timing_auto_model_inst (
        .pclk(pclk), .presetn(presetn), .bump(bump),
        .hs_zero_auto(au[0]), .hs_trail_auto(au[1]),
        .hs_exit_auto(au[2]), .plx_auto(au[3]));
    initial begin
        pclk = 0;
        forever #10 pclk = ~pclk;
    end
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task give_verdict;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : give_verdict
    // entered just after an edge; leaves one idle edge so strobes never clash
    task xfer(input logic w, input logic [ADDR_W-1:0] ad, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= ad; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask : xfer
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            fail_count++;
            give_verdict();
        end
    end
    initial begin
        presetn = 0; clk_en = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; pstrb = 4'hF; bump = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        for (int i = 0; i < 4; i++) begin
            a = ADDR_W'(4 * (IDX_HS_ZERO + i));
            v = 7'(7'h30 + i);
            xfer(0, a, 0);
            chk(rd, {25'h0, au[i]});
            chk(er, 0);
            chk({sl[i], ef[i]}, {1'b0, au[i]});
            xfer(1, a, 32'h55);
            xfer(0, a, 0);
            chk(rd, {25'h0, au[i]});
            chk(ef[i], au[i]);
            xfer(1, a, {24'h0, 1'b1, v});
            xfer(0, a, 0);
            chk(rd, {24'h0, 1'b1, v});
            bump <= 1;
            @(posedge pclk);
            bump <= 0;
            @(posedge pclk);
            chk({sl[i], ef[i]}, {1'b1, v});
            xfer(1, a, 0);
            xfer(0, a, 0);
            chk(rd, {25'h0, au[i]});
            $display("register %0d done", i);
        end
        // unmapped place and a write while clocks are gated off
        xfer(1, 10'h124, 32'hFF);
        chk(er, 1);
        xfer(0, 10'h124, 0);
        chk(rd, 0);
        clk_en <= 0;
        xfer(1, 10'h114, 32'h85);
        clk_en <= 1;
        xfer(0, 10'h114, 0);
        chk(rd, {25'h0, au[0]});
        // byte lane 0 disabled: write must not land
        pstrb <= 4'h0;
        xfer(1, 10'h118, 32'h80);
        pstrb <= 4'hF;
        xfer(0, 10'h118, 0);
        chk(rd, {25'h0, au[1]});
        $display("refusal test done");
        // reset in mid-run drops a live override
        xfer(1, 10'h114, 32'hAA);
        chk({sl[0], ef[0]}, {1'b1, 7'h2A});
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        chk({sl[0], ef[0]}, {1'b0, au[0]});
        xfer(0, 10'h114, 0);
        chk(rd, {25'h0, au[0]});
        $display("reset test done");
        give_verdict();
    end
endmodule : csi_hs_timing_override_regs_tb
